// [fpp_defs.vh]
// Constants for the flash protection and word-program block.
`ifndef FPP_DEFS_VH
`define FPP_DEFS_VH

// ==========================================================================
// Register map (printed offsets are not word multiples: index times four)
`define FPP_IDX_STATUS     12'h105
`define FPP_IDX_COMMAND    12'h106
`define FPP_IDX_PROTECT    12'h104
`define FPP_IDX_CONFIG     12'h103
`define FPP_IDX_ADDR       12'h108
`define FPP_IDX_DATA       12'h109
`define FPP_IDX_STORE      12'h10a

// ==========================================================================
// Protection register fields
`define FPP_PR_OPEN        7
`define FPP_PR_HDIS        5
`define FPP_PR_HS_HI       4
`define FPP_PR_HS_LO       3
`define FPP_PR_LDIS        2
`define FPP_PR_LS_HI       1
`define FPP_PR_LS_LO       0

// ==========================================================================
// Status register fields
`define FPP_ST_CBEIF       7
`define FPP_ST_CCIF        6
`define FPP_ST_PROTECTION_VIOLATION_FLAG       5
`define FPP_ST_ACCESS_ERROR_FLAG      4
`define FPP_ST_BLANK       2

// ==========================================================================
// Commands, block geometry and timing
`define FPP_CMD_PROGRAM    8'h20
`define FPP_CMD_MASS_ERASE 8'h41
`define FPP_CMD_SECT_ERASE 8'h40
`define FPP_BLOCK_TOP      16'hffff
`define FPP_LOWER_BASE     16'h8000
`define FPP_ROW_WORDS_LOG2 5
`define FPP_PROG_TIME_NS   40000
`define FPP_BURST_TIME_NS  20000
`define FPP_CLK_PERIOD_NS  25
`define FPP_PROG_CYCLES    (`FPP_PROG_TIME_NS / `FPP_CLK_PERIOD_NS)
`define FPP_BURST_CYCLES   (`FPP_BURST_TIME_NS / `FPP_CLK_PERIOD_NS)
`define FPP_BLANK_BYTE     8'hff
`define FPP_NUM_BLOCKS     4

`endif

// [fpp_area_check.v]
// Protection window check for one target address against one protection byte.
`default_nettype none
`include "fpp_defs.vh"

module fpp_area_check (
  // Protection setting
  input  wire [7:0]  prot_in,
  // Target
  input  wire [15:0] addr_in,
  input  wire        mass_in,
  // Result
  output reg         hit_out
);

  reg [15:0] upper_size;
  reg [15:0] lower_size;
  reg        in_upper;
  reg        in_lower;

  always @* begin
    upper_size = 16'h0000;
    lower_size = 16'h0000;
    case (prot_in[`FPP_PR_HS_HI:`FPP_PR_HS_LO])
      2'h0: upper_size = 16'h0800;
      2'h1: upper_size = 16'h1000;
      2'h2: upper_size = 16'h2000;
      default: upper_size = 16'h4000;
    endcase
    case (prot_in[`FPP_PR_LS_HI:`FPP_PR_LS_LO])
      2'h0: lower_size = 16'h0200;
      2'h1: lower_size = 16'h0400;
      2'h2: lower_size = 16'h0800;
      default: lower_size = 16'h1000;
    endcase
    // Upper area grows down from the block top; a set disable bit leaves it open.
    in_upper = !prot_in[`FPP_PR_HDIS] && (addr_in > (`FPP_BLOCK_TOP - upper_size));
    // Lower area grows up from its fixed base.
    in_lower = !prot_in[`FPP_PR_LDIS] && (addr_in >= `FPP_LOWER_BASE) &&
               (addr_in < (`FPP_LOWER_BASE + lower_size));
    if (!prot_in[`FPP_PR_OPEN]) begin
      hit_out = 1'b1;
    end else if (mass_in) begin
      hit_out = !(prot_in[`FPP_PR_HDIS] && prot_in[`FPP_PR_LDIS]);
    end else begin
      hit_out = in_upper || in_lower;
    end
  end

endmodule

`default_nettype wire

// [fpp_word_timer.v]
// Program pulse timer: full time for a new row, half time for a burst in the same row.
`default_nettype none
`include "fpp_defs.vh"

module fpp_word_timer (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // Control
  input  wire        start_in,
  input  wire        burst_in,
  // Status
  output wire        busy_out,
  output reg         done_out
);

  localparam [31:0] PROG_CYC_W  = `FPP_PROG_CYCLES;
  localparam [31:0] BURST_CYC_W = `FPP_BURST_CYCLES;
  localparam [15:0] PROG_CYC    = PROG_CYC_W[15:0];
  localparam [15:0] BURST_CYC   = BURST_CYC_W[15:0];

  reg [15:0] count;

  assign busy_out = (count != 16'h0000);

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count    <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count <= burst_in ? BURST_CYC : PROG_CYC;
      end else if (count != 16'h0000) begin
        count <= count - 16'h0001;
        done_out <= (count == 16'h0001);
      end
    end
  end

endmodule

`default_nettype wire

// [fpp_flash_protect.v]
// Flash protection registers, status and word-program command launch behind APB.
//
// Operation
// - Disable bit set leaves that area open
// - Upper area protected, sized by upper size
// - Lower area protected, sized by lower size
// - Upper size codes: 2k, 4k, 8k, 16k
// - Lower size codes: 512, 1k, 2k, 4k
// - Open bit zero protects whole block
// - Open bit one: areas decide protection
// - Command into protected area sets violation
// - Mass erase refused with access error; only program launches
// - Reset loads protection from stored bytes
// - Software may only clear protection bits
// - Stored bytes refused when block0 upper protected
// - Cleared open bit holds until reset
// - Error flags report failed launch
// - Flash blocked while busy; complete flag after
// - Same-row queued words burst, half time
// - Protection registers share address via select
// - Erased byte means protection disabled
`default_nettype none
`include "fpp_defs.vh"

module fpp_flash_protect (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_n_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output reg  [31:0] prdata_out,
  // Stored protection bytes, sampled on the first clock after reset is released
  input  wire [31:0] stored_prot_in,
  // Flash array program port
  output reg         prog_strobe_out,
  output reg  [15:0] prog_addr_out,
  output reg  [15:0] prog_data_out,
  output reg  [1:0]  prog_block_out,
  output wire        flash_busy_out
);

  // ==========================================================================
  // Register decode
  localparam [13:0] A_STATUS  = {`FPP_IDX_STATUS, 2'b00};
  localparam [13:0] A_COMMAND = {`FPP_IDX_COMMAND, 2'b00};
  localparam [13:0] A_PROTECT = {`FPP_IDX_PROTECT, 2'b00};
  localparam [13:0] A_CONFIG  = {`FPP_IDX_CONFIG, 2'b00};
  localparam [13:0] A_ADDR    = {`FPP_IDX_ADDR, 2'b00};
  localparam [13:0] A_DATA    = {`FPP_IDX_DATA, 2'b00};
  localparam [13:0] A_STORE   = {`FPP_IDX_STORE, 2'b00};

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOAD = 2'h1;
  localparam [1:0] S_RUN  = 2'h2;

  wire [13:0] byte_addr = {paddr_in, 2'b00};
  wire        access    = psel_in && penable_in;
  wire        wr        = access && pwrite_in;
  wire        hit_any   = (byte_addr == A_STATUS) || (byte_addr == A_COMMAND) ||
                          (byte_addr == A_PROTECT) || (byte_addr == A_CONFIG) ||
                          (byte_addr == A_ADDR) || (byte_addr == A_DATA) ||
                          (byte_addr == A_STORE);

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !hit_any;

  // ==========================================================================
  // State
  reg [1:0]  state;
  reg [7:0]  prot [0:`FPP_NUM_BLOCKS-1];
  reg [1:0]  block_sel;
  reg        cbeif;
  reg        ccif;
  reg        protection_violation_flag;
  reg        access_error_flag;
  reg [7:0]  command;
  reg [15:0] buf_addr;
  reg [15:0] buf_data;
  reg        addr_written;
  reg        cmd_written;
  reg        queued;
  reg [15:0] q_addr;
  reg [15:0] q_data;
  reg [1:0]  q_block;
  reg        has_last;
  reg [15:0] last_addr;

  wire       timer_busy;
  wire       timer_done;
  wire       prot_hit;
  wire       store_hit;
  wire [7:0] prot_active = prot[block_sel];
  wire       is_mass     = (command == `FPP_CMD_MASS_ERASE);

  fpp_area_check u_check (
    .prot_in (prot_active),
    .addr_in (buf_addr),
    .mass_in (is_mass),
    .hit_out (prot_hit)
  );

  // Stored bytes sit in the top 2k of block 0, inside its smallest upper area.
  fpp_area_check u_store (
    .prot_in (prot[0]),
    .addr_in (`FPP_BLOCK_TOP),
    .mass_in (1'b0),
    .hit_out (store_hit)
  );

  // ==========================================================================
  // Launch qualification
  wire w_status  = wr && (byte_addr == A_STATUS);
  wire launch    = w_status && pwdata_in[`FPP_ST_CBEIF] && cbeif;
  wire seq_ok    = addr_written && cmd_written && !buf_addr[0] &&
                   (command == `FPP_CMD_PROGRAM);
  wire launch_ok = launch && seq_ok && !prot_hit && !protection_violation_flag && !access_error_flag;
  wire same_row  = has_last &&
                   (buf_addr[15:`FPP_ROW_WORDS_LOG2+1] == last_addr[15:`FPP_ROW_WORDS_LOG2+1]);
  wire start     = (state == S_IDLE || timer_done) && queued;

  fpp_word_timer u_timer (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .start_in   (start),
    .burst_in   (same_row && timer_done),
    .busy_out   (timer_busy),
    .done_out   (timer_done)
  );

  assign flash_busy_out = !ccif;

  // ==========================================================================
  // Protection registers
  genvar g;
  generate
    for (g = 0; g < `FPP_NUM_BLOCKS; g = g + 1) begin : g_prot
      always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          prot[g] <= `FPP_BLANK_BYTE;
        end else if (state == S_LOAD) begin
          prot[g] <= stored_prot_in[8*g+7:8*g];
        end else if (wr && byte_addr == A_PROTECT && block_sel == g) begin
          // Only clears stick; the open bit once cleared stays cleared.
          prot[g] <= prot[g] & pwdata_in[7:0];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Command, status and sequencing
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state           <= S_LOAD;
      block_sel       <= 2'h0;
      cbeif           <= 1'b1;
      ccif            <= 1'b1;
      protection_violation_flag           <= 1'b0;
      access_error_flag          <= 1'b0;
      command         <= 8'h00;
      buf_addr        <= 16'h0000;
      buf_data        <= 16'h0000;
      addr_written    <= 1'b0;
      cmd_written     <= 1'b0;
      queued          <= 1'b0;
      q_addr          <= 16'h0000;
      q_data          <= 16'h0000;
      q_block         <= 2'h0;
      has_last        <= 1'b0;
      last_addr       <= 16'h0000;
      prog_strobe_out <= 1'b0;
      prog_addr_out   <= 16'h0000;
      prog_data_out   <= 16'h0000;
      prog_block_out  <= 2'h0;
    end else begin
      prog_strobe_out <= 1'b0;
      case (state)
        S_LOAD: begin
          state <= S_IDLE;
        end
        S_IDLE, S_RUN: begin
          if (start) begin
            state           <= S_RUN;
            queued          <= 1'b0;
            cbeif           <= 1'b1;
            prog_strobe_out <= 1'b1;
            prog_addr_out   <= q_addr;
            prog_data_out   <= q_data;
            prog_block_out  <= q_block;
            last_addr       <= q_addr;
            has_last        <= 1'b1;
          end else if (timer_done && !queued) begin
            state    <= S_IDLE;
            ccif     <= 1'b1;
            has_last <= 1'b0;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase

      if (wr && byte_addr == A_CONFIG) begin
        block_sel <= pwdata_in[1:0];
      end
      if (wr && byte_addr == A_ADDR && cbeif) begin
        buf_addr     <= pwdata_in[15:0];
        addr_written <= 1'b1;
      end
      if (wr && byte_addr == A_DATA && cbeif) begin
        buf_data     <= pwdata_in[15:0];
      end
      if (wr && byte_addr == A_COMMAND && cbeif) begin
        command     <= pwdata_in[7:0];
        cmd_written <= 1'b1;
      end

      // Writes of one clear the error flags; a new error in the same cycle wins.
      if (w_status && pwdata_in[`FPP_ST_PROTECTION_VIOLATION_FLAG]) begin
        protection_violation_flag <= 1'b0;
      end
      if (w_status && pwdata_in[`FPP_ST_ACCESS_ERROR_FLAG]) begin
        access_error_flag <= 1'b0;
      end

      // A write to the stored bytes only raises a violation when block 0's top word is protected.
      if (wr && byte_addr == A_STORE && store_hit) begin
        protection_violation_flag <= 1'b1;
      end

      if (launch) begin
        addr_written <= 1'b0;
        cmd_written  <= 1'b0;
        if (!seq_ok) begin
          access_error_flag <= 1'b1;
        end else if (prot_hit) begin
          protection_violation_flag <= 1'b1;
        end else if (launch_ok) begin
          queued  <= 1'b1;
          q_addr  <= buf_addr;
          q_data  <= buf_data;
          q_block <= block_sel;
          cbeif   <= 1'b0;
          ccif    <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Read data
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      case ({paddr_in, 2'b00})
        A_STATUS:  prdata_out <= {24'h000000, cbeif, ccif, protection_violation_flag, access_error_flag, 4'h0};
        A_COMMAND: prdata_out <= {24'h000000, command};
        A_PROTECT: prdata_out <= {24'h000000, prot_active};
        A_CONFIG:  prdata_out <= {30'h00000000, block_sel};
        A_ADDR:    prdata_out <= {16'h0000, buf_addr};
        A_DATA:    prdata_out <= {16'h0000, buf_data};
        A_STORE:   prdata_out <= {prot[3], prot[2], prot[1], prot[0]};
        default:   prdata_out <= 32'h00000000;
      endcase
    end
  end

  // Timer busy is informational only; completion is carried by its done pulse.
  wire unused_ok = timer_busy;

endmodule

`default_nettype wire

// [fpp_flash_protect_sva.sv]
// Assertion checker bound to the flash protection block.
`default_nettype none
`include "fpp_defs.vh"
module fpp_flash_protect_sva (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  // Flash side
  input wire logic [31:0] stored_prot_in,
  input wire logic        prog_strobe_out,
  input wire logic [15:0] prog_addr_out,
  input wire logic [15:0] prog_data_out,
  input wire logic [1:0]  prog_block_out,
  input wire logic        flash_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_PULSE = 790;
  int  since_strobe;
  wire launch_w = psel_in & penable_in & pwrite_in & (paddr_in == `FPP_IDX_STATUS) & pwdata_in[`FPP_ST_CBEIF];
  wire rd_setup_w = psel_in & ~penable_in & ~pwrite_in;
  wire mapped_w = paddr_in inside {`FPP_IDX_STATUS, `FPP_IDX_COMMAND, `FPP_IDX_PROTECT, `FPP_IDX_CONFIG,
                                   `FPP_IDX_ADDR, `FPP_IDX_DATA, `FPP_IDX_STORE};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ========================================
  // Cycles since the last program strobe
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      since_strobe <= 0;
    end else if (prog_strobe_out) begin
      since_strobe <= 1;
    end else if (since_strobe < 4000) begin
      since_strobe <= since_strobe + 1;
    end
  end
  sequence s_accept;
    launch_w ##1 $rose(flash_busy_out);
  endsequence
  sequence s_word;
    prog_strobe_out ##1 (flash_busy_out && !prog_strobe_out) [*8];
  endsequence
  // ========================================
  // Properties
  AST_ZERO_WAIT: assert property (psel_in && penable_in |-> pready_out)
    else $error("Access phase without ready");
  AST_DECODE_ERR: assert property (psel_in && penable_in |-> pslverr_out == !mapped_w)
    else $error("Slave error does not follow the address map");
  AST_BUSY_FROM_LAUNCH: assert property ($rose(flash_busy_out) |-> $past(launch_w))
    else $error("Busy rose without a launch");
  AST_WORD_START: assert property (s_accept |=> s_word)
    else $error("Accepted launch gave no single program strobe");
  AST_STROBE_BUSY: assert property (prog_strobe_out |-> flash_busy_out)
    else $error("Program strobe while idle");
  AST_EVEN_TARGET: assert property (prog_strobe_out |-> !prog_addr_out[0])
    else $error("Odd program address launched");
  AST_PULSE_LENGTH: assert property ($fell(flash_busy_out) |-> since_strobe >= MIN_PULSE)
    else $error("Program pulse too short");
  AST_TARGET_HELD: assert property (!prog_strobe_out |-> $stable({prog_addr_out, prog_data_out, prog_block_out}))
    else $error("Program target changed without strobe");
  AST_READ_HELD: assert property (!rd_setup_w |=> $stable(prdata_out))
    else $error("Read data changed outside a read setup");
endmodule
bind fpp_flash_protect fpp_flash_protect_sva chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .stored_prot_in(stored_prot_in),
  .prog_strobe_out(prog_strobe_out), .prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out),
  .prog_block_out(prog_block_out), .flash_busy_out(flash_busy_out));
`default_nettype wire

// [fpp_host_model.sv]
// Host software model: APB master issuing flash word-program sequences.
`default_nettype none
`include "fpp_defs.vh"
module fpp_host_model (
  // Clock and APB answer
  input  wire logic        clk_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  // APB request
  output var  logic        psel_out,
  output var  logic        penable_out,
  output var  logic        pwrite_out,
  output var  logic [11:0] paddr_out,
  output var  logic [31:0] pwdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata;
  logic        err;
  logic        hung = 1'b0;
  initial begin
    {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  end
  // Released address and data lines show the inverse, so no stale value can pass.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_out    <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out  <= w;
    paddr_out   <= a;
    pwdata_out  <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 64);
    rdata = prdata_in;
    err   = pslverr_in;
    if (n >= 64) hung = 1'b1;
    psel_out    <= 1'b0;
    penable_out <= 1'b0;
    paddr_out   <= ~a;
    pwdata_out  <= ~d;
  endtask
  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    xfer(1'b1, `FPP_IDX_STATUS, 32'h30);
    do begin
      xfer(1'b0, `FPP_IDX_STATUS, 32'h0);
      n++;
    end while (rdata[`FPP_ST_CBEIF] !== 1'b1 && n < 4000);
    if (n >= 4000) hung = 1'b1;
    xfer(1'b1, `FPP_IDX_ADDR, {16'h0, a});
    xfer(1'b1, `FPP_IDX_DATA, {16'h0, d});
    xfer(1'b1, `FPP_IDX_COMMAND, {24'h0, `FPP_CMD_PROGRAM});
    xfer(1'b1, `FPP_IDX_STATUS, 32'h80);
  endtask
endmodule
`default_nettype wire

// [fpp_flash_protect_test.sv]
// Testbench for the flash protection and word-program block.
`default_nettype none
`include "fpp_defs.vh"
module fpp_flash_protect_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] blk; logic [8:0] pw; logic [15:0] a; logic pv;} fpp_row_t;
  // ========================================
  // Wiring
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, strobe, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] stored_prot = 32'hff7f_98ff;
  logic [15:0] p_addr, p_data;
  logic [1:0]  p_blk;
  int          n_fail = 0;
  int          num_checks = 0;
  int          busy_run = 0;
  int          busy_len = 0;
  // Block, protection write (bit 8 enables it), target, violation expected.
  fpp_row_t rows [14] = '{'{2'd0, 9'h000, 16'h9000, 1'b0}, '{2'd1, 9'h000, 16'hc000, 1'b1},
    '{2'd1, 9'h000, 16'hbffe, 1'b0}, '{2'd1, 9'h000, 16'h81fe, 1'b1}, '{2'd1, 9'h000, 16'h8200, 1'b0},
    '{2'd2, 9'h000, 16'h9000, 1'b1}, '{2'd3, 9'h1cf, 16'hf000, 1'b1}, '{2'd3, 9'h000, 16'heffe, 1'b0},
    '{2'd3, 9'h1c7, 16'hf800, 1'b1}, '{2'd3, 9'h000, 16'hf7fe, 1'b0}, '{2'd3, 9'h1c3, 16'h8ffe, 1'b1},
    '{2'd3, 9'h1c2, 16'h8800, 1'b0}, '{2'd3, 9'h000, 16'h87fe, 1'b1}, '{2'd3, 9'h1ff, 16'h9000, 1'b0}};
  initial forever #12.5 clk_in = ~clk_in;
  fpp_flash_protect dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
    .prdata_out(prdata), .stored_prot_in(stored_prot), .prog_strobe_out(strobe), .prog_addr_out(p_addr),
    .prog_data_out(p_data), .prog_block_out(p_blk), .flash_busy_out(busy));
  fpp_host_model host (.clk_in(clk_in), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
  always @(posedge clk_in) begin
    if (busy) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end
  // ========================================
  // Tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    reset_n_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    check(n < 5000, 1'b1);
  endtask
  task automatic rd_status;
    host.xfer(1'b0, `FPP_IDX_STATUS, 32'h0);
  endtask
  // ========================================
  // Sequence
  initial begin
    #(25ns * 60000);
    n_fail++;
    conclude();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      host.xfer(1'b1, `FPP_IDX_CONFIG, {30'h0, rows[i].blk});
      if (rows[i].pw[8]) host.xfer(1'b1, `FPP_IDX_PROTECT, {24'h0, rows[i].pw[7:0]});
      host.prog(rows[i].a, ~rows[i].a);
      rd_status();
      check(host.rdata[`FPP_ST_PROTECTION_VIOLATION_FLAG], rows[i].pv);
      if (!rows[i].pv) begin
        wait_idle();
        check({p_blk, p_addr, p_data}, {rows[i].blk, rows[i].a, ~rows[i].a});
      end
    end
    for (int b = 0; b < 4; b++) begin
      host.xfer(1'b1, `FPP_IDX_CONFIG, 32'(b));
      host.xfer(1'b0, `FPP_IDX_PROTECT, 32'h0);
      check(host.rdata[7:0], (b == 3) ? 8'hc2 : stored_prot[8*b +: 8]);
    end
    host.xfer(1'b1, `FPP_IDX_CONFIG, 32'h0);
    host.prog(16'h9100, 16'h1234);
    host.prog(16'h9102, 16'h5678);
    rd_status();
    check(host.rdata[`FPP_ST_CCIF], 1'b0);
    wait_idle();
    rd_status();
    check(host.rdata[7:6], 2'b11);
    check(busy_len inside {[2400:2420]}, 1'b1);
    host.xfer(1'b1, `FPP_IDX_STATUS, 32'h30);
    host.xfer(1'b1, `FPP_IDX_STATUS, 32'h80);
    rd_status();
    check({host.rdata[`FPP_ST_ACCESS_ERROR_FLAG], busy}, 2'b10);
    host.prog(16'h9001, 16'h0);
    rd_status();
    check(host.rdata[`FPP_ST_ACCESS_ERROR_FLAG], 1'b1);
    host.xfer(1'b0, 12'h100, 32'h0);
    check(host.err, 1'b1);
    host.xfer(1'b1, `FPP_IDX_STATUS, 32'h30);
    host.xfer(1'b1, `FPP_IDX_STORE, 32'h0);
    rd_status();
    check(host.rdata[`FPP_ST_PROTECTION_VIOLATION_FLAG], 1'b0);
    host.xfer(1'b1, `FPP_IDX_PROTECT, 32'h7f);
    host.prog(16'h9000, 16'h0);
    rd_status();
    check(host.rdata[`FPP_ST_PROTECTION_VIOLATION_FLAG], 1'b1);
    host.xfer(1'b1, `FPP_IDX_PROTECT, 32'hff);
    host.xfer(1'b0, `FPP_IDX_PROTECT, 32'h0);
    check(host.rdata[7:0], 8'h7f);
    host.xfer(1'b1, `FPP_IDX_STATUS, 32'h30);
    host.xfer(1'b1, `FPP_IDX_STORE, 32'h0);
    rd_status();
    check(host.rdata[`FPP_ST_PROTECTION_VIOLATION_FLAG], 1'b1);
    do_reset();
    host.xfer(1'b0, `FPP_IDX_PROTECT, 32'h0);
    check(host.rdata[7:0], 8'hff);
    check(host.hung, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
